// ==== hdl/hsw_consts.vh ====
// Constants shared by the watchdog block: offsets, fields, reset values
`ifndef HSW_CONSTS_VH
`define HSW_CONSTS_VH

// ==================================================
// Register offsets
`define HSW_ADDR_W 16
`define HSW_OFF_CONTROL 16'h000c
`define HSW_OFF_STATUS 16'h000d

// ==================================================
// Control register fields
`define HSW_BIT_CLK_SEL_HI 7
`define HSW_BIT_CLK_SEL_LO 6
`define HSW_BIT_SUB_OSC_PICK 5
`define HSW_BIT_HW_MODE_FLAG 4
`define HSW_KEY_MSB 3
`define HSW_KEY_LSB 0
`define HSW_KEY_CODE 4'h5
`define HSW_KEY_READ 4'h0

// ==================================================
// Reset and read values
`define HSW_CTRL_RESET_SW 8'h00
`define HSW_CTRL_VALUE_HW 8'h30
`define HSW_SEL_RESET 3'h0
`define HSW_SEL_HW 3'h1

// ==================================================
// Status register fields
`define HSW_STAT_ACTIVE 0
`define HSW_STAT_COUNT 1
`define HSW_STAT_RUNNING 2
`define HSW_STAT_STBY_RUN 3

// ==================================================
// Tick source indices into the synchronised source vector
`define HSW_SRC_TBT21 0
`define HSW_SRC_TBT20 1
`define HSW_SRC_WP14 2
`define HSW_SRC_WP13 3
`define HSW_SRC_SCR16 4
`define HSW_SRC_NUM 5

`endif

// ==== hdl/hsw_sync.v ====
// Two-stage synchroniser for a vector of independent levels
`timescale 1ns/10ps
module hsw_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage feeds the second stage only
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// ==== hdl/hsw_tick_sel.v ====
// Count source selector turning the chosen prescaler output into enable pulses
`timescale 1ns/10ps
`include "hsw_consts.vh"
module hsw_tick_sel (
  input wire i_clk,
  input wire i_rst_n,
  input wire [`HSW_SRC_NUM-1:0] i_src,
  input wire [2:0] i_sel,
  input wire i_restart,
  output wire o_tick
);
  reg prev_q;
  reg level;

  // ==================================================
  // Source decode: {clock_sel_hi, clock_sel_lo, sub_osc_pick}
  always @* begin
    level = 1'b0;
    if (i_sel[0]) begin
      level = i_src[`HSW_SRC_SCR16];
    end else begin
      case (i_sel[2:1])
        2'b00: level = i_src[`HSW_SRC_TBT21];
        2'b01: level = i_src[`HSW_SRC_TBT20];
        2'b10: level = i_src[`HSW_SRC_WP14];
        2'b11: level = i_src[`HSW_SRC_WP13];
        default: level = 1'b0;
      endcase
    end
  end

  // ==================================================
  // Rising edge of the selected output is one tick
  // Restart reloads the history so a source switch made in a restart cycle gives no false tick
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q <= 1'b0;
    end else if (i_restart) begin
      prev_q <= level;
    end else begin
      prev_q <= level;
    end
  end

  assign o_tick = level & ~prev_q & ~i_restart;
endmodule

// ==== hdl/hsw_watchdog.v ====
// Hardware/software watchdog timer with its control register and reset request
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "hsw_consts.vh"
module hsw_watchdog #(
  parameter ADDR_W = `HSW_ADDR_W
) (
  input wire i_mclk,
  input wire i_reset_n,
  // Register port
  input wire [ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [7:0] o_rdata,
  // Prescaler outputs, asynchronous square waves
  input wire i_tbt_out21,
  input wire i_tbt_out20,
  input wire i_wp_out14,
  input wire i_wp_out13,
  input wire i_scr_out16,
  // Prescaler clear pulses, same clock
  input wire i_tbt_clear,
  input wire i_wp_clear,
  input wire i_scr_clear,
  // System state, same clock
  input wire i_standby,
  // Nonvolatile selection copy
  input wire i_nv_hw_mode,
  input wire i_nv_hw_stby_run,
  // Reset request and state
  output wire o_wdt_reset_req,
  output wire o_active
);

  // ==================================================
  // Address decode
  function addr_hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // ==================================================
  // Count source decode
  function clear_of_sel;
    input [2:0] sel;
    input tbt_clr;
    input wp_clr;
    input scr_clr;
    begin
      if (sel[0]) begin
        clear_of_sel = scr_clr;
      end else if (sel[2]) begin
        clear_of_sel = wp_clr;
      end else begin
        clear_of_sel = tbt_clr;
      end
    end
  endfunction

  // ==================================================
  // Reset release through two flops
  // Every flop but these two leaves reset on the same retimed edge
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ==================================================
  // Strap capture
  reg strap_done_q;
  reg hw_mode_q;
  reg hw_stby_run_q;

  // capture mode straps once
  // Async reset loads constants; straps are taken on the first clocked cycle
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      hw_mode_q <= 1'b0;
      hw_stby_run_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      hw_mode_q <= i_nv_hw_mode;
      hw_stby_run_q <= i_nv_hw_mode & i_nv_hw_stby_run;
    end
  end

  // ==================================================
  // Source synchronisation and tick generation
  wire [`HSW_SRC_NUM-1:0] src_async;
  wire [`HSW_SRC_NUM-1:0] src_sync;
  wire tick;

  assign src_async = {i_scr_out16, i_wp_out13, i_wp_out14, i_tbt_out20, i_tbt_out21};

  hsw_sync #(
    .WIDTH(`HSW_SRC_NUM)
  ) u_src_sync (
    .i_clk(i_mclk),
    .i_rst_n(rst_n),
    .i_async(src_async),
    .o_sync(src_sync)
  );

  // ==================================================
  // Control register state
  reg [2:0] sel_q;
  reg sw_active_q;
  reg count_q;
  reg reset_req_q;
  reg [7:0] rdata_q;
  reg stopped_q;

  wire wr_ctrl;
  wire rd_ctrl;
  wire rd_stat;
  wire key_ok;
  wire [2:0] eff_sel;
  wire active;
  wire stby_stop;
  wire running;
  wire src_clear;
  wire key_clear;
  wire counter_clear;
  wire restart;

  assign wr_ctrl = i_wr & addr_hit(i_addr, `HSW_OFF_CONTROL);
  assign rd_ctrl = i_rd & addr_hit(i_addr, `HSW_OFF_CONTROL);
  assign rd_stat = i_rd & addr_hit(i_addr, `HSW_OFF_STATUS);

  assign key_ok = wr_ctrl & (i_wdata[`HSW_KEY_MSB:`HSW_KEY_LSB] == `HSW_KEY_CODE);

  // hardware mode forces the sub-oscillator source
  assign eff_sel = hw_mode_q ? `HSW_SEL_HW : sel_q;

  // software activation only when hardware mode is off
  assign active = (hw_mode_q & strap_done_q) | sw_active_q;

  // standby stops the counter unless hardware standby running
  assign stby_stop = i_standby & ~hw_stby_run_q;
  assign running = active & ~stby_stop;

  // clearing the prescaler in use clears the counter
  assign src_clear = clear_of_sel(eff_sel, i_tbt_clear, i_wp_clear, i_scr_clear);

  // key on an already running watchdog is a clear
  assign key_clear = key_ok & active;

  assign counter_clear = src_clear | key_clear | ~running;

  // Source history is reloaded whenever counting restarts
  assign restart = counter_clear | (running & stopped_q);

  // ticks are one-cycle enables on the system clock
  hsw_tick_sel u_tick_sel (
    .i_clk(i_mclk),
    .i_rst_n(rst_n),
    .i_src(src_sync),
    .i_sel(eff_sel),
    .i_restart(restart),
    .o_tick(tick)
  );

  // ==================================================
  // Activation and clock selection
  // first key write after reset activates
  // nothing but reset drops the activation
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      sw_active_q <= 1'b0;
    end else if (key_ok & ~hw_mode_q & strap_done_q) begin
      sw_active_q <= 1'b1;
    end
  end

  // select bits writable in software mode, reset to zero
  // full-byte writes assumed; a merged write would also carry the key
  // Locked after activation except alongside a valid key, so a stray write
  // cannot retune a running watchdog
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= `HSW_SEL_RESET;
    end else if (wr_ctrl & ~hw_mode_q & (~sw_active_q | key_ok)) begin
      sel_q <= {i_wdata[`HSW_BIT_CLK_SEL_HI], i_wdata[`HSW_BIT_CLK_SEL_LO],
                i_wdata[`HSW_BIT_SUB_OSC_PICK]};
    end
  end

  // ==================================================
  // Counter and overflow
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      stopped_q <= 1'b1;
    end else begin
      stopped_q <= ~running;
    end
  end

  // A clear beats a same-cycle tick, so a last-moment key still rescues
  // one-bit counter, tick advances it
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 1'b0;
    end else if (counter_clear) begin
      count_q <= 1'b0;
    end else if (tick) begin
      count_q <= ~count_q;
    end
  end

  // tick on a full counter overflows
  // Request holds until the chip reset takes effect
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      reset_req_q <= 1'b0;
    end else if (~counter_clear & tick & count_q) begin
      reset_req_q <= 1'b1;
    end
  end

  // ==================================================
  // Read words, assembled by field position
  reg [7:0] ctrl_word;
  reg [7:0] stat_word;

  always @* begin
    ctrl_word = `HSW_CTRL_RESET_SW;
    if (hw_mode_q) begin
      ctrl_word = `HSW_CTRL_VALUE_HW;
    end else begin
      ctrl_word[`HSW_BIT_CLK_SEL_HI] = sel_q[2];
      ctrl_word[`HSW_BIT_CLK_SEL_LO] = sel_q[1];
      ctrl_word[`HSW_BIT_SUB_OSC_PICK] = sel_q[0];
      ctrl_word[`HSW_BIT_HW_MODE_FLAG] = 1'b0;
    end
    ctrl_word[`HSW_KEY_MSB:`HSW_KEY_LSB] = `HSW_KEY_READ;
  end

  // Status word is local to this block, not part of the control register
  always @* begin
    stat_word = 8'h00;
    stat_word[`HSW_STAT_ACTIVE] = active;
    stat_word[`HSW_STAT_COUNT] = count_q;
    stat_word[`HSW_STAT_RUNNING] = running;
    stat_word[`HSW_STAT_STBY_RUN] = hw_stby_run_q;
  end

  // ==================================================
  // Read path
  // Data stand one cycle after the strobe, zero otherwise
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (rd_ctrl) begin
      rdata_q <= ctrl_word;
    end else if (rd_stat) begin
      rdata_q <= stat_word;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;
  assign o_wdt_reset_req = reset_req_q;
  assign o_active = active;

endmodule

// ==== verification/hsw_watchdog_checker.sv ====
// Port-level assertions for the watchdog block
`timescale 1ns/10ps
`include "hsw_consts.vh"
module hsw_watchdog_checker #(
  parameter ADDR_W = 16
) (
  input wire i_mclk,
  input wire i_reset_n,
  input wire [ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire i_standby,
  input wire i_nv_hw_mode,
  input wire i_nv_hw_stby_run,
  input wire o_wdt_reset_req,
  input wire o_active
);
  // ==================================================
  // Properties
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  wire ctl_wr = i_wr && (i_addr == `HSW_OFF_CONTROL);
  wire key_ok = (i_wdata[3:0] == `HSW_KEY_CODE);
  wire sw = !i_nv_hw_mode;
  a_key_reads_zero: assert property ($past(i_rd) && $past(i_addr) == `HSW_OFF_CONTROL
    |-> o_rdata[3:0] == 4'h0) else $error("key field read not zero");
  a_hw_ctrl_fixed: assert property ($past(i_rd) && $past(i_addr) == `HSW_OFF_CONTROL &&
    i_nv_hw_mode |-> o_rdata == 8'h30) else $error("hardware mode control read wrong");
  a_sw_flag_low: assert property ($past(i_rd) && $past(i_addr) == `HSW_OFF_CONTROL &&
    sw |-> !o_rdata[4]) else $error("mode flag set in software mode");
  a_key_activates: assert property (sw && ctl_wr && key_ok |=> o_active)
    else $error("key write did not activate");
  a_bad_key_idle: assert property (sw && !o_active && i_wr && !key_ok |=> !o_active)
    else $error("wrong key activated");
  a_active_holds: assert property (o_active |=> o_active)
    else $error("active watchdog stopped");
  a_req_holds: assert property (o_wdt_reset_req |=> o_wdt_reset_req)
    else $error("reset request dropped");
  a_req_when_active: assert property ($rose(o_wdt_reset_req) |-> $past(o_active))
    else $error("request while inactive");
  a_stby_blocks_req: assert property ($rose(o_wdt_reset_req) && !i_nv_hw_stby_run |->
    !$past(i_standby) && !$past(i_standby, 2))
    else $error("request raised in standby");
  c_overflow: cover property ($rose(o_wdt_reset_req));
  c_key_clear: cover property (ctl_wr && key_ok && o_active);
  c_hw_read: cover property ($past(i_rd) && i_nv_hw_mode);
endmodule

bind hsw_watchdog hsw_watchdog_checker #(.ADDR_W(ADDR_W)) chk_inst (.*);

// ==== verification/hsw_watchdog_tb.sv ====
// Self-checking bench for the watchdog block
`timescale 1ns/10ps
`include "hsw_consts.vh"
module hsw_watchdog_tb;
  localparam [15:0] ctl_addr = `HSW_OFF_CONTROL;
  reg i_mclk = 1'b0;
  reg i_reset_n = 1'b0;
  reg [15:0] i_addr = 16'h0000;
  reg [7:0] i_wdata = 8'h00;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg [4:0] src = 5'h00;
  reg [2:0] clr = 3'h0;
  reg stby = 1'b0;
  reg hw = 1'b0;
  reg hw_run = 1'b0;
  wire [7:0] o_rdata;
  wire o_wdt_reset_req;
  wire o_active;
  reg [7:0] d;
  integer fail_count = 0;
  integer num_checks = 0;
  integer k;
  integer s;
  initial forever #10 i_mclk = ~i_mclk;
  hsw_watchdog hsw_watchdog_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tbt_out21(src[0]),
    .i_tbt_out20(src[1]), .i_wp_out14(src[2]), .i_wp_out13(src[3]), .i_scr_out16(src[4]),
    .i_tbt_clear(clr[0]), .i_wp_clear(clr[1]), .i_scr_clear(clr[2]), .i_standby(stby),
    .i_nv_hw_mode(hw), .i_nv_hw_stby_run(hw_run), .o_wdt_reset_req(o_wdt_reset_req),
    .o_active(o_active));
  // ==================================================
  // Tasks
  task chk(input string name, input [7:0] seen, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  task chkf(input e_act, input e_req);
    begin
      #1;
      chk("active", {7'h00, o_active}, {7'h00, e_act});
      chk("req", {7'h00, o_wdt_reset_req}, {7'h00, e_req});
    end
  endtask
  task wr(input [15:0] a, input [7:0] v);
    begin
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
    end
  endtask
  // Data stand only in the cycle after the strobe
  task rd(input [15:0] a, output [7:0] v);
    begin
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      v = o_rdata;
    end
  endtask
  // Straps change only while reset is held
  task rst(input h, input r);
    begin
      @(posedge i_mclk);
      hw <= h;
      hw_run <= r;
      i_reset_n <= 1'b0;
      repeat (5) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      repeat (4) @(posedge i_mclk);
    end
  endtask
  // Slow square pulse, long enough to pass the synchroniser
  task edge_on(input integer i);
    begin
      @(posedge i_mclk);
      src[i] <= 1'b1;
      repeat (8) @(posedge i_mclk);
      src[i] <= 1'b0;
      repeat (8) @(posedge i_mclk);
    end
  endtask
  // One-cycle clear pulse of prescaler i: 0 time-base, 1 watch, 2 low-speed
  task pulse_clr(input integer i);
    begin
      @(posedge i_mclk);
      clr[i] <= 1'b1;
      @(posedge i_mclk);
      clr[i] <= 1'b0;
    end
  endtask
  task act(input [7:0] v);
    begin
      rst(1'b0, 1'b0);
      wr(ctl_addr, v);
      chkf(1'b1, 1'b0);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // ==================================================
  // Sequence
  initial begin
    repeat (60000) @(posedge i_mclk);
    fail_count = fail_count + 1;
    end_of_test;
  end
  initial begin
    rst(1'b0, 1'b0);
    rd(ctl_addr, d);
    chk("ctrl_reset", d, 8'h00);
    rd(16'h0020, d);
    chk("unmapped", d, 8'h00);
    for (k = 0; k < 8; k = k + 1) begin
      wr(ctl_addr, {k[2:0], 5'h1a});
      rd(ctl_addr, d);
      chk("sel_rw", d, {k[2:0], 5'h00});
    end
    chkf(1'b0, 1'b0);
    $display("test registers done");
    for (k = 0; k < 5; k = k + 1) begin
      act((k == 4) ? 8'he5 : {k[1:0], 6'h05});
      edge_on((k + 1) % 5);
      edge_on((k + 1) % 5);
      edge_on(k);
      pulse_clr((k < 2) ? 1 : ((k < 4) ? 2 : 0));
      chkf(1'b1, 1'b0);
      edge_on(k);
      chkf(1'b1, 1'b1);
    end
    $display("test sources done");
    for (k = 0; k < 4; k = k + 1) begin
      s = (k == 3) ? 2 : 0;
      act((k == 3) ? 8'h85 : 8'h05);
      edge_on(s);
      rd(`HSW_OFF_STATUS, d);
      chk("status_run", d, 8'h07);
      if (k == 0) begin
        wr(ctl_addr, 8'h05);
      end else if (k == 2) begin
        @(posedge i_mclk);
        stby <= 1'b1;
        edge_on(s);
        edge_on(s);
        rd(`HSW_OFF_STATUS, d);
        chk("status_stby", d, 8'h01);
        @(posedge i_mclk);
        stby <= 1'b0;
      end else begin
        pulse_clr(k >> 1);
      end
      wr(ctl_addr, 8'h0a);
      edge_on(s);
      chkf(1'b1, 1'b0);
      edge_on(s);
      chkf(1'b1, 1'b1);
    end
    $display("test clears done");
    rst(1'b1, 1'b0);
    chkf(1'b1, 1'b0);
    wr(ctl_addr, 8'hc0);
    rd(ctl_addr, d);
    chk("ctrl_hw", d, 8'h30);
    edge_on(0);
    edge_on(0);
    edge_on(4);
    wr(ctl_addr, 8'h05);
    edge_on(4);
    chkf(1'b1, 1'b0);
    pulse_clr(2);
    edge_on(4);
    chkf(1'b1, 1'b0);
    edge_on(4);
    chkf(1'b1, 1'b1);
    rst(1'b1, 1'b1);
    stby <= 1'b1;
    edge_on(4);
    edge_on(4);
    chkf(1'b1, 1'b1);
    $display("test hardware mode done");
    end_of_test;
  end
endmodule
